// [rtl/atms_key_cond.sv]
// key pin synchroniser with press pulse and long-hold pulse
`timescale 1ns/10ps
module atms_key_cond #(
    parameter int unsigned HOLD_CYC = atms_pkg::HOLD_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic keyPin,
    output atms_pkg::atms_key_t key
);
    import atms_pkg::*;

    typedef struct packed {
        logic [2:0] sync;
        logic stable;
        logic [CNT_W-1:0] cnt;
        logic fired;
        atms_key_t key;
    } atms_kc_t;

    localparam logic [CNT_W-1:0] LAST = CNT_W'(HOLD_CYC - 1);
    atms_kc_t s_q;
    atms_kc_t s_d;

    always_comb
    begin
        s_d = s_q;
        s_d.sync = {s_q.sync[1:0], keyPin};
        if (s_q.sync[1] == s_q.sync[2])
            s_d.stable = s_q.sync[2];
        s_d.key.level = s_d.stable;
        s_d.key.press = s_d.stable && !s_q.stable;
        s_d.key.hold = 1'b0;
        if (!s_d.stable)
        begin
            s_d.cnt = '0;
            s_d.fired = 1'b0;
        end
        else if (s_q.cnt != LAST)
            s_d.cnt = s_q.cnt + CNT_W'(1);
        else if (!s_q.fired)
        begin
            s_d.key.hold = 1'b1;
            s_d.fired = 1'b1;
        end
    end

    always_ff @(posedge clk)
        if (rst)
            s_q <= '0;
        else
            s_q <= s_d;

    assign key = s_q.key;
endmodule : atms_key_cond

// [rtl/atms_pkg.sv]
// shared constants and types for the tuning and hand-control sequencer
package atms_pkg;
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned HOLD_TIME_S = 3;
    localparam int unsigned HOLD_CYC = CLK_HZ * HOLD_TIME_S;
    localparam int unsigned TICK_TIME_S = 1;
    localparam int unsigned TICK_CYC = CLK_HZ * TICK_TIME_S;
    localparam int unsigned CNT_W = 27;

    localparam logic [15:0] PB_LIMIT = 16'h2328;
    localparam logic [15:0] TI_LIMIT = 16'h03e8;
    localparam logic [15:0] MV_MAX = 16'h03e8;
    localparam logic [15:0] MV_STEP = 16'h0001;
    localparam logic [15:0] PB_RST = 16'h00b4;
    localparam logic [15:0] TI_RST = 16'h0064;

    localparam logic [7:0] REG_PB_A = 8'h00;
    localparam logic [7:0] REG_TI_A = 8'h04;
    localparam logic [7:0] REG_PB_B = 8'h08;
    localparam logic [7:0] REG_TI_B = 8'h0c;
    localparam logic [7:0] REG_CFG = 8'h10;
    localparam logic [7:0] REG_FAIL = 8'h14;
    localparam logic [7:0] REG_STAT = 8'h18;
    localparam logic [7:0] REG_MV = 8'h1c;

    localparam int unsigned CFG_W = 5;
    localparam int unsigned CFG_COOL = 0;
    localparam int unsigned CFG_RAMP = 1;
    localparam int unsigned CFG_PUMP = 3;
    localparam int unsigned CFG_HOLD = 4;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_WARM = 6'h02,
        ST_WAIT = 6'h04,
        ST_LEARN = 6'h08,
        ST_MANUAL = 6'h10,
        ST_SPARE = 6'h20
    } atms_state_t;

    typedef struct packed {
        logic level;
        logic press;
        logic hold;
    } atms_key_t;

    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } atms_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } atms_axi_rsp_t;
endpackage : atms_pkg

// [rtl/atms_sequencer.sv]
// auto-tune and hand-control sequencer with register slave
//
// Local design decisions: the register addresses and the AXI4-Lite register port.
`timescale 1ns/10ps
module atms_sequencer #(
    parameter int unsigned HOLD_CYC = atms_pkg::HOLD_CYC,
    parameter int unsigned TICK_CYC = atms_pkg::TICK_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire atms_pkg::atms_axi_req_t axiReq,
    output atms_pkg::atms_axi_rsp_t axiRsp,
    input wire logic selKeyPin,
    input wire logic upKeyPin,
    input wire logic downKeyPin,
    input wire logic tuneMenuShown,
    input wire logic handMenuShown,
    input wire logic eventSetB,
    input wire logic nearSetpoint,
    input wire logic atSetpoint,
    input wire logic setpointChanged,
    input wire logic failMode,
    input wire logic onOffCycleDone,
    input wire logic unstable,
    input wire logic [15:0] newPb,
    input wire logic [15:0] newTi,
    input wire logic [15:0] newTd,
    input wire logic [15:0] avgHeatMv,
    input wire logic [15:0] avgCoolMv,
    output logic upperFlash,
    output logic lowerShowsCool,
    output logic tuneErrorFlag,
    output logic pidEnable,
    output logic onOffEnable,
    output logic openLoop,
    output logic manualFromFail,
    output logic [2:0] funcDisable,
    output logic [15:0] heatManipulatedValue,
    output logic [15:0] coolManipulatedValue,
    output logic coolDriveEn,
    output logic pidAdjust,
    output logic nvWrite,
    output logic nvSetB,
    output logic [15:0] nvPb,
    output logic [15:0] nvTi,
    output logic [15:0] nvTd
);
    import atms_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    typedef struct packed {
        atms_state_t st;
        logic err;
        logic prevFail;
        logic showCool;
        logic [1:0] cyc;
        logic [16:0] waitCnt;
        logic [15:0] pbA;
        logic [15:0] tiA;
        logic [15:0] pbB;
        logic [15:0] tiB;
        logic [15:0] failVal;
        logic [15:0] heatMv;
        logic [15:0] coolMv;
        logic [CFG_W-1:0] cfg;
        logic flash;
        logic man;
        logic pidOn;
        logic onOff;
        logic coolEn;
        logic adj;
        logic nvWr;
        logic nvB;
        logic [2:0] fOff;
        logic [15:0] nPb;
        logic [15:0] nTi;
        logic [15:0] nTd;
        logic awHave;
        logic wHave;
        logic [7:0] awAddr;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic awRdy;
        logic wRdy;
        logic bValid;
        logic [1:0] bResp;
        logic arRdy;
        logic rValid;
        logic [1:0] rResp;
        logic [31:0] rData;
    } atms_seq_t;

    atms_seq_t s_q;
    atms_seq_t s_d;
    atms_key_t selKey;
    atms_key_t upKey;
    atms_key_t downKey;
    logic secTick;
    logic [15:0] actPb;
    logic [15:0] actTi;
    logic [16:0] twoTi;
    logic okPb;
    logic okStart;
    logic tuning;
    logic anyPress;
    logic exitCombo;
    logic tooBig;
    logic errSet;

    function automatic logic [15:0] wmerge(
        input logic [15:0] old,
        input logic [31:0] d,
        input logic [3:0] be
    );
        wmerge = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
    endfunction : wmerge

    function automatic logic [15:0] stepMv(
        input logic [15:0] v,
        input logic up
    );
        if (up)
            stepMv = (v >= MV_MAX) ? MV_MAX : v + MV_STEP;
        else
            stepMv = (v == 16'h0000) ? 16'h0000 : v - MV_STEP;
    endfunction : stepMv

    atms_key_cond #(.HOLD_CYC(HOLD_CYC)) selCond (
        .clk(clk),
        .rst(rst),
        .keyPin(selKeyPin),
        .key(selKey)
    );
    atms_key_cond #(.HOLD_CYC(HOLD_CYC)) upCond (
        .clk(clk),
        .rst(rst),
        .keyPin(upKeyPin),
        .key(upKey)
    );
    atms_key_cond #(.HOLD_CYC(HOLD_CYC)) downCond (
        .clk(clk),
        .rst(rst),
        .keyPin(downKeyPin),
        .key(downKey)
    );
    atms_tick #(.TICK_CYC(TICK_CYC)) secTimer (
        .clk(clk),
        .rst(rst),
        .tick(secTick)
    );

    // event input picks the active parameter set
    assign actPb = eventSetB ? s_q.pbB : s_q.pbA;
    assign actTi = eventSetB ? s_q.tiB : s_q.tiA;
    assign twoTi = {actTi, 1'b0};
    assign okPb = actPb != 16'h0000;
    assign okStart = okPb && actTi != 16'h0000;
    assign tuning = s_q.st == ST_WARM || s_q.st == ST_WAIT
        || s_q.st == ST_LEARN;
    assign anyPress = selKey.press || upKey.press || downKey.press;
    assign exitCombo = upKey.level && downKey.level;
    assign tooBig = newPb > PB_LIMIT || newTi > TI_LIMIT;
    assign errSet = (tuning && setpointChanged) || (s_q.st == ST_LEARN
        && onOffCycleDone && s_q.cyc != 2'h0 && tooBig);

    always_comb
    begin
        s_d = s_q;
        s_d.nvWr = 1'b0;
        // write channels, taken in either order
        if (axiReq.awvalid && s_q.awRdy)
        begin
            s_d.awHave = 1'b1;
            s_d.awAddr = axiReq.awaddr;
        end
        if (axiReq.wvalid && s_q.wRdy)
        begin
            s_d.wHave = 1'b1;
            s_d.wData = axiReq.wdata;
            s_d.wStrb = axiReq.wstrb;
        end
        if (s_q.bValid && axiReq.bready)
            s_d.bValid = 1'b0;
        if (s_q.awHave && s_q.wHave && !s_q.bValid)
        begin
            s_d.awHave = 1'b0;
            s_d.wHave = 1'b0;
            s_d.bValid = 1'b1;
            s_d.bResp = RESP_OKAY;
            unique case (s_q.awAddr)
                REG_PB_A: s_d.pbA = wmerge(s_q.pbA, s_q.wData, s_q.wStrb);
                REG_TI_A: s_d.tiA = wmerge(s_q.tiA, s_q.wData, s_q.wStrb);
                REG_PB_B: s_d.pbB = wmerge(s_q.pbB, s_q.wData, s_q.wStrb);
                REG_TI_B: s_d.tiB = wmerge(s_q.tiB, s_q.wData, s_q.wStrb);
                REG_FAIL:
                    s_d.failVal = wmerge(s_q.failVal, s_q.wData, s_q.wStrb);
                REG_CFG:
                    if (s_q.wStrb[0])
                        s_d.cfg = s_q.wData[CFG_W-1:0];
                REG_STAT, REG_MV: ;
                default: s_d.bResp = RESP_SLVERR;
            endcase
        end
        s_d.awRdy = !s_d.awHave && !s_d.bValid;
        s_d.wRdy = !s_d.wHave && !s_d.bValid;
        // read channel
        if (s_q.rValid && axiReq.rready)
            s_d.rValid = 1'b0;
        if (axiReq.arvalid && s_q.arRdy)
        begin
            s_d.rValid = 1'b1;
            s_d.rResp = RESP_OKAY;
            unique case (axiReq.araddr)
                REG_PB_A: s_d.rData = 32'(s_q.pbA);
                REG_TI_A: s_d.rData = 32'(s_q.tiA);
                REG_PB_B: s_d.rData = 32'(s_q.pbB);
                REG_TI_B: s_d.rData = 32'(s_q.tiB);
                REG_CFG: s_d.rData = 32'(s_q.cfg);
                REG_FAIL: s_d.rData = 32'(s_q.failVal);
                REG_STAT: s_d.rData = 32'({s_q.cyc, s_q.prevFail,
                    s_q.showCool, s_q.err, s_q.st});
                REG_MV: s_d.rData = {s_q.coolMv, s_q.heatMv};
                default:
                begin
                    s_d.rData = 32'h0000_0000;
                    s_d.rResp = RESP_SLVERR;
                end
            endcase
        end
        s_d.arRdy = !s_d.rValid;

        // key press clears, a new error in the same cycle wins
        if (anyPress)
            s_d.err = 1'b0;
        if (tuning && setpointChanged)
        begin
            s_d.err = 1'b1;
            s_d.st = ST_IDLE;
        end
        else
        begin
            unique case (s_q.st)
                ST_IDLE:
                    if (tuneMenuShown && selKey.hold && okStart)
                    begin
                        s_d.st = nearSetpoint ? ST_WAIT : ST_WARM;
                        s_d.waitCnt = twoTi;
                    end
                    else if (handMenuShown && selKey.hold && okPb)
                    begin
                        s_d.st = ST_MANUAL;
                        s_d.prevFail = failMode;
                        s_d.showCool = 1'b0;
                        s_d.heatMv = s_q.cfg[CFG_HOLD] ? avgHeatMv : s_q.failVal;
                        s_d.coolMv = s_q.cfg[CFG_HOLD] ? avgCoolMv : s_q.failVal;
                    end
                ST_WARM:
                    if (atSetpoint)
                    begin
                        s_d.st = ST_WAIT;
                        s_d.waitCnt = twoTi;
                    end
                ST_WAIT:
                    if (secTick)
                    begin
                        if (s_q.waitCnt <= 17'h0_0001)
                        begin
                            s_d.st = ST_LEARN;
                            s_d.cyc = 2'h0;
                        end
                        else
                            s_d.waitCnt = s_q.waitCnt - 17'h0_0001;
                    end
                ST_LEARN:
                    if (onOffCycleDone)
                    begin
                        if (s_q.cyc == 2'h0)
                            s_d.cyc = 2'h1;
                        else if (tooBig)
                        begin
                            s_d.err = 1'b1;
                            s_d.st = ST_IDLE;
                        end
                        else
                        begin
                            s_d.st = ST_IDLE;
                            s_d.nvWr = 1'b1;
                            s_d.nvB = eventSetB;
                            s_d.nPb = newPb;
                            s_d.nTi = newTi;
                            s_d.nTd = newTd;
                            if (eventSetB)
                            begin
                                s_d.pbB = newPb;
                                s_d.tiB = newTi;
                            end
                            else
                            begin
                                s_d.pbA = newPb;
                                s_d.tiA = newTi;
                            end
                        end
                    end
                ST_MANUAL:
                    if (exitCombo)
                        s_d.st = ST_IDLE;
                    else if (selKey.press)
                        s_d.showCool = !s_q.showCool;
                    else if (upKey.press || downKey.press)
                    begin
                        if (s_q.showCool)
                            s_d.coolMv = stepMv(s_q.coolMv, upKey.press);
                        else
                            s_d.heatMv = stepMv(s_q.heatMv, upKey.press);
                    end
                default: s_d.st = ST_IDLE;
            endcase
        end
        s_d.adj = unstable && (s_q.st == ST_WARM || s_q.st == ST_WAIT);
        s_d.flash = s_d.st != ST_IDLE;
        s_d.man = s_d.st == ST_MANUAL;
        s_d.onOff = s_d.st == ST_LEARN;
        s_d.pidOn = !s_d.onOff && !s_d.man;
        s_d.fOff = (s_d.flash && !s_d.man) ? s_q.cfg[CFG_PUMP:CFG_RAMP]
            : 3'h0;
        s_d.coolEn = s_d.man && s_d.cfg[CFG_COOL];
    end

    always_ff @(posedge clk)
        if (rst)
        begin
            s_q <= '0;
            s_q.st <= ST_IDLE;
            s_q.pbA <= PB_RST;
            s_q.tiA <= TI_RST;
            s_q.pbB <= PB_RST;
            s_q.tiB <= TI_RST;
            s_q.pidOn <= 1'b1;
        end
        else
            s_q <= s_d;

    assign axiRsp.awready = s_q.awRdy;
    assign axiRsp.wready = s_q.wRdy;
    assign axiRsp.bvalid = s_q.bValid;
    assign axiRsp.bresp = s_q.bResp;
    assign axiRsp.arready = s_q.arRdy;
    assign axiRsp.rvalid = s_q.rValid;
    assign axiRsp.rdata = s_q.rData;
    assign axiRsp.rresp = s_q.rResp;
    assign upperFlash = s_q.flash;
    assign lowerShowsCool = s_q.showCool;
    assign tuneErrorFlag = s_q.err;
    assign pidEnable = s_q.pidOn;
    assign onOffEnable = s_q.onOff;
    assign openLoop = s_q.man;
    assign manualFromFail = s_q.prevFail;
    assign funcDisable = s_q.fOff;
    assign heatManipulatedValue = s_q.heatMv;
    assign coolManipulatedValue = s_q.coolMv;
    assign coolDriveEn = s_q.coolEn;
    assign pidAdjust = s_q.adj;
    assign nvWrite = s_q.nvWr;
    assign nvSetB = s_q.nvB;
    assign nvPb = s_q.nPb;
    assign nvTi = s_q.nTi;
    assign nvTd = s_q.nTd;

    tune_flash_a: assert property (tuning |-> upperFlash)
        else $error("flash missing while tuning");
    tune_refuse_a: assert property ($rose(tuning) |-> $past(okStart))
        else $error("tuning started with zero parameter");
    wait_len_a: assert property (
        (s_q.st == ST_WARM && atSetpoint && !setpointChanged)
        |=> s_q.st == ST_WAIT && s_q.waitCnt == $past(twoTi))
        else $error("waiting count not twice integral time");
    learn_mode_a: assert property (
        s_q.st == ST_LEARN |-> onOffEnable && !pidEnable)
        else $error("learning without on-off control");
    store_two_a: assert property (
        nvWrite |-> $past(s_q.st) == ST_LEARN && $past(s_q.cyc) == 2'h1)
        else $error("store without two on-off cycles");
    err_limit_a: assert property (
        (s_q.st == ST_LEARN && onOffCycleDone && s_q.cyc == 2'h1
        && tooBig) |=> tuneErrorFlag && !nvWrite ##1 !nvWrite)
        else $error("limit breach not flagged");
    sp_change_a: assert property (
        (tuning && setpointChanged) |=> tuneErrorFlag && !upperFlash)
        else $error("set point change not flagged");
    key_clear_a: assert property (
        (tuneErrorFlag && anyPress && !errSet) |=> !tuneErrorFlag)
        else $error("key press left error");
    manual_pb_a: assert property ($rose(openLoop) |-> $past(okPb))
        else $error("manual entered with zero band");
    cool_gate_a: assert property (
        coolDriveEn |-> openLoop && s_q.cfg[CFG_COOL])
        else $error("cool driven outside manual cooling");
    manual_exit_a: assert property (
        (openLoop && exitCombo) |=> !openLoop && pidEnable)
        else $error("exit keys did not leave manual");
endmodule : atms_sequencer

// [rtl/atms_tick.sv]
// one-second timebase pulse
`timescale 1ns/10ps
module atms_tick #(
    parameter int unsigned TICK_CYC = atms_pkg::TICK_CYC
) (
    input wire logic clk,
    input wire logic rst,
    output logic tick
);
    import atms_pkg::*;

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic tick;
    } atms_tk_t;

    localparam logic [CNT_W-1:0] LAST = CNT_W'(TICK_CYC - 1);
    atms_tk_t s_q;
    atms_tk_t s_d;

    always_comb
    begin
        s_d.tick = s_q.cnt == LAST;
        s_d.cnt = s_d.tick ? '0 : s_q.cnt + CNT_W'(1);
    end

    always_ff @(posedge clk)
        if (rst)
            s_q <= '0;
        else
            s_q <= s_d;

    assign tick = s_q.tick;
endmodule : atms_tick

// [testbench/atms_process_model.sv]
// process stand-in producing ON-OFF learning cycles and results
`timescale 1ns/10ps
module atms_process_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic onOffEnable,
    input wire logic [3:0] halfPeriod,
    input wire logic [15:0] pbRes,
    input wire logic [15:0] tiRes,
    output logic onOffCycleDone,
    output logic [15:0] newPb,
    output logic [15:0] newTi,
    output logic [15:0] newTd
);
    logic [3:0] cnt;
    // results only meaningful with the done pulse
    always @(posedge clk)
    begin
        onOffCycleDone <= 1'b0;
        newPb <= ~newPb;
        newTi <= ~newTi;
        newTd <= ~newTd;
        if (rst || !onOffEnable)
        begin
            cnt <= 4'h0;
        end
        else if (cnt == halfPeriod)
        begin
            cnt <= 4'h0;
            onOffCycleDone <= 1'b1;
            newPb <= pbRes;
            newTi <= tiRes;
            newTd <= 16'h0019;
        end
        else
        begin
            cnt <= cnt + 4'h1;
        end
    end
endmodule : atms_process_model

// [testbench/atms_sequencer_tb_top.sv]
// self-checking bench for the tuning and hand-control sequencer
`timescale 1ns/10ps
module atms_sequencer_tb_top;
    import atms_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    atms_axi_req_t req = '0;
    atms_axi_rsp_t rsp;
    logic sel = 1'b0, up = 1'b0, dn = 1'b0, tuneM = 1'b0, handM = 1'b0;
    logic evB = 1'b0, nearSp = 1'b0, atSp = 1'b0, spChg = 1'b0;
    logic unst = 1'b0, failM = 1'b0, mff;
    logic [3:0] half = 4'h4;
    logic [15:0] pbRes = 16'h0001, tiRes = 16'h0001;
    logic [15:0] avgH = 16'h0000, avgC = 16'h0000;
    logic done, fl, shC, err, pid, oo, ol, cde, padj, nvw, nvB;
    logic [2:0] fd;
    logic [15:0] nPb, nTi, nTd, hMv, cMv, nvPb, nvTi, nvTd;
    logic [31:0] rd, cfgv, failv;
    logic [1:0] rr;
    int fails = 0, num_checks = 0, nvCount = 0;

    always #12.5 clk = ~clk;
    always @(posedge clk) if (nvw === 1'b1) nvCount++;

    atms_sequencer #(.HOLD_CYC(20), .TICK_CYC(10)) dut (.clk(clk),
        .rst(rst), .axiReq(req), .axiRsp(rsp), .selKeyPin(sel),
        .upKeyPin(up), .downKeyPin(dn), .tuneMenuShown(tuneM),
        .handMenuShown(handM), .eventSetB(evB), .nearSetpoint(nearSp),
        .atSetpoint(atSp), .setpointChanged(spChg), .failMode(failM),
        .onOffCycleDone(done), .unstable(unst), .newPb(nPb),
        .newTi(nTi), .newTd(nTd), .avgHeatMv(avgH), .avgCoolMv(avgC),
        .upperFlash(fl), .lowerShowsCool(shC), .tuneErrorFlag(err),
        .pidEnable(pid), .onOffEnable(oo), .openLoop(ol),
        .manualFromFail(mff), .funcDisable(fd), .heatManipulatedValue(hMv),
        .coolManipulatedValue(cMv), .coolDriveEn(cde), .pidAdjust(padj),
        .nvWrite(nvw), .nvSetB(nvB), .nvPb(nvPb), .nvTi(nvTi),
        .nvTd(nvTd));

    atms_process_model procModel (.clk(clk), .rst(rst),
        .onOffEnable(oo), .halfPeriod(half), .pbRes(pbRes),
        .tiRes(tiRes), .onOffCycleDone(done), .newPb(nPb),
        .newTi(nTi), .newTd(nTd));

    task automatic report_and_stop;
        if (fails == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : report_and_stop

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            $display("unexpected at %0t: got %h expected %h", $time, got,
                exp);
            fails++;
        end
    endtask : check

    task automatic give_up;
        fails++;
        report_and_stop;
    endtask : give_up

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= d;
        req.wstrb <= 4'hf;
        req.bready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (rsp.awready === 1'b1) req.awvalid <= 1'b0;
            if (rsp.wready === 1'b1) req.wvalid <= 1'b0;
            if (++n > 60) give_up;
        end
        while (rsp.bvalid !== 1'b1);
        rr = rsp.bresp;
        req.bready <= 1'b0;
        @(posedge clk);
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a);
        int n;
        n = 0;
        req.arvalid <= 1'b1;
        req.araddr <= a;
        req.rready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (rsp.arready === 1'b1) req.arvalid <= 1'b0;
            if (++n > 60) give_up;
        end
        while (rsp.rvalid !== 1'b1);
        rd = rsp.rdata;
        rr = rsp.rresp;
        req.rready <= 1'b0;
        @(posedge clk);
    endtask : axi_rd

    task automatic wait_state(input logic [5:0] s);
        int n;
        n = 0;
        do
        begin
            axi_rd(REG_STAT);
            if (++n > 200) give_up;
        end
        while (rd[5:0] !== s);
    endtask : wait_state

    // mask is {select, up, down}
    task automatic keys(input logic [2:0] m, input int cyc);
        {sel, up, dn} <= m;
        repeat (cyc) @(posedge clk);
        {sel, up, dn} <= 3'b000;
        repeat (8) @(posedge clk);
    endtask : keys

    // value a manual output takes on entry
    function automatic logic [15:0] entry_mv(
        input logic hold,
        input logic [15:0] avg,
        input logic [15:0] fv
    );
        entry_mv = hold ? avg : fv;
    endfunction : entry_mv

    initial
    begin
        rd = $urandom(38517);
        cfgv = $urandom & 32'h0000_001f;
        failM <= 1'($urandom);
        failv = $urandom % 1000;
        avgH <= 16'($urandom % 1000);
        avgC <= 16'($urandom % 1000);
        half <= 4'h4 + 4'($urandom % 5);
        pbRes <= 16'h0001 + 16'($urandom % 9000);
        tiRes <= 16'h0001 + 16'($urandom % 1000);
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        axi_rd(8'h40);
        check({rr, rd}, {RESP_SLVERR, 32'h0000_0000});
        axi_wr(8'h40, 32'h0000_0001);
        check(rr, RESP_SLVERR);
        axi_wr(REG_TI_A, 32'h0000_0002);
        axi_wr(REG_TI_B, 32'h0000_0003);
        axi_wr(REG_CFG, cfgv);
        check(rr, RESP_OKAY);
        axi_rd(REG_CFG);
        check(rd, cfgv);
        tuneM <= 1'b1;
        keys(3'b100, 30);
        check(fl, 1'b1);
        check(fd, cfgv[3:1]);
        axi_rd(REG_STAT);
        check(rd[5:0], 6'h02);
        atSp <= 1'b1;
        wait_state(6'h04);
        unst <= 1'b1;
        @(posedge clk);
        unst <= 1'b0;
        @(posedge clk);
        check(padj, 1'b1);
        wait_state(6'h08);
        check({oo, pid}, 2'b10);
        wait_state(6'h01);
        check(nvCount, 1);
        check({nvPb, nvTi, nvTd}, {pbRes, tiRes, 16'h0019});
        check({fl, pid, nvB}, 3'b010);
        nearSp <= 1'b1;
        keys(3'b100, 30);
        spChg <= 1'b1;
        @(posedge clk);
        spChg <= 1'b0;
        repeat (2) @(posedge clk);
        check(err, 1'b1);
        keys(3'b001, 4);
        check(err, 1'b0);
        evB <= 1'b1;
        pbRes <= 16'h2329;
        keys(3'b100, 30);
        axi_rd(REG_STAT);
        check(rd[5:0], 6'h04);
        wait_state(6'h01);
        check(err, 1'b1);
        check({nvCount, nvB}, {32'd1, 1'b0});
        axi_rd(REG_PB_B);
        check(rd, {16'h0000, PB_RST});
        keys(3'b010, 4);
        check(err, 1'b0);
        axi_wr(REG_PB_B, 32'h0000_0000);
        keys(3'b100, 30);
        check({fl, oo}, 2'b00);
        tuneM <= 1'b0;
        handM <= 1'b1;
        keys(3'b100, 30);
        check(ol, 1'b0);
        axi_wr(REG_PB_B, 32'h0000_00b4);
        axi_wr(REG_FAIL, failv);
        keys(3'b100, 30);
        check({ol, fl, shC}, 3'b110);
        check(hMv, entry_mv(cfgv[4], avgH, failv[15:0]));
        check(mff, failM);
        check(cde, cfgv[0]);
        keys(3'b100, 4);
        check(shC, 1'b1);
        keys(3'b010, 4);
        check(cMv, entry_mv(cfgv[4], avgC, failv[15:0]) + 16'h0001);
        keys(3'b100, 4);
        check(shC, 1'b0);
        keys(3'b011, 8);
        check({ol, pid}, 2'b01);
        handM <= 1'b0;
        report_and_stop;
    end
endmodule : atms_sequencer_tb_top
